/* gpio_alt_pkg.sv */
// package for the three-port gpio block with port d alternate overrides
// assumes an apb master with 32-bit data and word-aligned register addresses
package gpio_alt_pkg;

  localparam int ADDR_W = 8;

  // register byte addresses
  localparam logic [7:0] OFS_B_OUTPUT = 8'h00;
  localparam logic [7:0] OFS_B_DIRECTION = 8'h04;
  localparam logic [7:0] OFS_B_PIN_LEVEL = 8'h08;
  localparam logic [7:0] OFS_C_OUTPUT = 8'h0C;
  localparam logic [7:0] OFS_C_DIRECTION = 8'h10;
  localparam logic [7:0] OFS_C_PIN_LEVEL = 8'h14;
  localparam logic [7:0] OFS_D_OUTPUT = 8'h18;
  localparam logic [7:0] OFS_D_DIRECTION = 8'h1C;
  localparam logic [7:0] OFS_D_PIN_LEVEL = 8'h20;
  localparam logic [7:0] OFS_ALT_CONTROL = 8'h24;
  localparam logic [7:0] OFS_PINCHG_MASK = 8'h28;

  // reset values
  localparam logic [7:0] RST_PORT = 8'h00;
  localparam logic [11:0] RST_ALT_CONTROL = 12'h000;
  localparam logic [7:0] RST_PINCHG_MASK = 8'h00;

  // port c has seven pins; bit 7 is not implemented
  localparam logic [7:0] PORT_C_MASK = 8'h7F;

  // alternate control field positions
  localparam int CTL_PULLUP_DIS = 0;
  localparam int CTL_TX_EN = 1;
  localparam int CTL_RX_EN = 2;
  localparam int CTL_SYNC_SEL = 3;
  localparam int CTL_IRQ0_EN = 4;
  localparam int CTL_IRQ1_EN = 5;
  localparam int CTL_PCG1_EN = 6;
  localparam int CTL_PCG2_EN = 7;
  localparam int CTL_T0A_EN = 8;
  localparam int CTL_T0B_EN = 9;
  localparam int CTL_T2B_EN = 10;
  localparam int CTL_DIN_GATE = 11;
  localparam int CTL_W = 12;

endpackage : gpio_alt_pkg

/* gpio_ports_with_alt_override.sv */
// three general-purpose ports (b and d 8-bit, c 7-bit) behind an apb slave;
// port d carries serial, timer and interrupt alternate-function overrides.
// assumes pins are asynchronous to pclk; peripheral signals come from pclk logic.
//
// Local design decisions: the APB interface to the registers and the register offsets.
`timescale 1ns/1ps

// What this block does
// - transmitter enabled: port d bit 1 is an output carrying transmit data
// - receiver enabled: port d bit 0 is an input regardless of direction
// - forced receive input: pull-up on if data bit one and pull-ups not disabled
// - port d bit 3 input on for irq one or its masked group-2 pin change
// - port d bit 2 input on for irq zero or its masked group-1 pin change
// - port d bit 4 input feeds pin change, sync serial clock and timer0 count
// - port d bit 2 is the source pin of external interrupt zero
// - port d bits 0..2 are pin-change sources 16, 17 and 18
// - port b data register: 8 bits read/write, reset zero
// - port b direction register: 8 bits read/write, reset zero, all inputs
// - port b pin level register: read-only, shows pin levels
// - port c data register bits 6..0 read/write reset zero, bit 7 reads zero
// - port c direction bits 6..0 read/write reset zero, bit 7 reads zero
// - port c pin level read-only, bits 6..0 pin levels, bit 7 zero
// - port d data register: 8 bits read/write, reset zero
// - port d direction register: 8 bits read/write, reset zero
// - port d pin level register: read-only, shows pin levels
module gpio_ports_with_alt_override #(
  parameter int PORT_W = 8,
  parameter int PORT_C_W = 7
) (
  // apb
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [gpio_alt_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // port b pins
  input wire logic [PORT_W-1:0] pb_pin_in,
  output logic [PORT_W-1:0] pb_pin_out,
  output logic [PORT_W-1:0] pb_pin_oe_n,
  output logic [PORT_W-1:0] pb_pullup,
  // port c pins
  input wire logic [PORT_C_W-1:0] pc_pin_in,
  output logic [PORT_C_W-1:0] pc_pin_out,
  output logic [PORT_C_W-1:0] pc_pin_oe_n,
  output logic [PORT_C_W-1:0] pc_pullup,
  // port d pins
  input wire logic [PORT_W-1:0] pd_pin_in,
  output logic [PORT_W-1:0] pd_pin_out,
  output logic [PORT_W-1:0] pd_pin_oe_n,
  output logic [PORT_W-1:0] pd_pullup,
  // alternate-function values from on-chip peripherals
  input wire logic serial_tx_data,
  input wire logic serial_sync_clock_out,
  input wire logic timer0_cmp_a_out,
  input wire logic timer0_cmp_b_out,
  input wire logic timer2_cmp_b_out,
  // digital inputs handed to on-chip peripherals
  output logic serial_rx_data,
  output logic serial_sync_clock_in,
  output logic ext_irq_zero,
  output logic ext_irq_one,
  output logic timer0_count_in,
  output logic timer1_count_in,
  output logic [PORT_W-1:0] pinchg_src
);

  // register state
  logic [7:0] port_b_output;
  logic [7:0] port_b_direction;
  logic [7:0] port_c_output;
  logic [7:0] port_c_direction;
  logic [7:0] port_d_output;
  logic [7:0] port_d_direction;
  logic [gpio_alt_pkg::CTL_W-1:0] alt_control;
  logic [7:0] pinchg_mask;
  logic [7:0] next_port_b_output;
  logic [7:0] next_port_b_direction;
  logic [7:0] next_port_c_output;
  logic [7:0] next_port_c_direction;
  logic [7:0] next_port_d_output;
  logic [7:0] next_port_d_direction;
  logic [gpio_alt_pkg::CTL_W-1:0] next_alt_control;
  logic [7:0] next_pinchg_mask;

  // apb answer state
  logic [31:0] next_prdata;
  logic next_pslverr;

  // pin sampling state
  logic [7:0] pb_sync1, pb_sync2, pc_sync1, pc_sync2, pd_sync1, pd_sync2;
  logic [7:0] port_b_pin_level, port_c_pin_level, port_d_pin_level;
  logic [7:0] next_port_b_pin_level, next_port_c_pin_level, next_port_d_pin_level;

  // pin drive state
  logic [7:0] next_pb_out, next_pb_oe_n, next_pb_pull;
  logic [7:0] next_pc_out, next_pc_oe_n, next_pc_pull;
  logic [7:0] next_pd_out, next_pd_oe_n, next_pd_pull;
  logic [7:0] pc_out_q, pc_oe_n_q, pc_pull_q;

  // override pairs per port d pin
  logic [7:0] pullup_override_en, pullup_override_val;
  logic [7:0] dir_override_en, dir_override_val;
  logic [7:0] value_override_en, value_override_val;
  logic [7:0] din_enable_override_en, din_enable_override_val;
  logic [7:0] pd_din_enable;

  logic global_pullup_disable, serial_tx_enable, serial_rx_enable, serial_sync_select;
  logic ext_irq_zero_en, ext_irq_one_en, pinchg_group1_enable, pinchg_group2_enable;
  logic din_gate;
  logic [7:0] pc_pin_in_w;
  logic wr_access, setup_read;

  assign global_pullup_disable = alt_control[gpio_alt_pkg::CTL_PULLUP_DIS];
  assign serial_tx_enable = alt_control[gpio_alt_pkg::CTL_TX_EN];
  assign serial_rx_enable = alt_control[gpio_alt_pkg::CTL_RX_EN];
  assign serial_sync_select = alt_control[gpio_alt_pkg::CTL_SYNC_SEL];
  assign ext_irq_zero_en = alt_control[gpio_alt_pkg::CTL_IRQ0_EN];
  assign ext_irq_one_en = alt_control[gpio_alt_pkg::CTL_IRQ1_EN];
  assign pinchg_group1_enable = alt_control[gpio_alt_pkg::CTL_PCG1_EN];
  assign pinchg_group2_enable = alt_control[gpio_alt_pkg::CTL_PCG2_EN];
  // when set, digital inputs read zero unless an override keeps them on
  assign din_gate = alt_control[gpio_alt_pkg::CTL_DIN_GATE];
  assign pc_pin_in_w = {1'b0, pc_pin_in};

  // zero-wait slave: read data is captured in the setup cycle
  assign pready = psel & penable;
  assign wr_access = psel & penable & pwrite;
  assign setup_read = psel & ~penable;

  // register writes
  always_comb begin
    next_port_b_output = port_b_output;
    next_port_b_direction = port_b_direction;
    next_port_c_output = port_c_output;
    next_port_c_direction = port_c_direction;
    next_port_d_output = port_d_output;
    next_port_d_direction = port_d_direction;
    next_alt_control = alt_control;
    next_pinchg_mask = pinchg_mask;
    if (wr_access) begin
      unique case (paddr)
        gpio_alt_pkg::OFS_B_OUTPUT: next_port_b_output = pwdata[7:0];
        gpio_alt_pkg::OFS_B_DIRECTION: next_port_b_direction = pwdata[7:0];
        gpio_alt_pkg::OFS_C_OUTPUT: begin
          next_port_c_output = pwdata[7:0] & gpio_alt_pkg::PORT_C_MASK;
        end
        gpio_alt_pkg::OFS_C_DIRECTION: begin
          next_port_c_direction = pwdata[7:0] & gpio_alt_pkg::PORT_C_MASK;
        end
        gpio_alt_pkg::OFS_D_OUTPUT: next_port_d_output = pwdata[7:0];
        gpio_alt_pkg::OFS_D_DIRECTION: next_port_d_direction = pwdata[7:0];
        gpio_alt_pkg::OFS_ALT_CONTROL: next_alt_control = pwdata[gpio_alt_pkg::CTL_W-1:0];
        gpio_alt_pkg::OFS_PINCHG_MASK: next_pinchg_mask = pwdata[7:0];
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      port_b_output <= gpio_alt_pkg::RST_PORT;
      port_b_direction <= gpio_alt_pkg::RST_PORT;
      port_c_output <= gpio_alt_pkg::RST_PORT;
      port_c_direction <= gpio_alt_pkg::RST_PORT;
      port_d_output <= gpio_alt_pkg::RST_PORT;
      port_d_direction <= gpio_alt_pkg::RST_PORT;
      alt_control <= gpio_alt_pkg::RST_ALT_CONTROL;
      pinchg_mask <= gpio_alt_pkg::RST_PINCHG_MASK;
    end else begin
      port_b_output <= next_port_b_output;
      port_b_direction <= next_port_b_direction;
      port_c_output <= next_port_c_output;
      port_c_direction <= next_port_c_direction;
      port_d_output <= next_port_d_output;
      port_d_direction <= next_port_d_direction;
      alt_control <= next_alt_control;
      pinchg_mask <= next_pinchg_mask;
    end
  end

  // read data and error, registered at the setup cycle
  always_comb begin
    next_prdata = prdata;
    next_pslverr = pslverr;
    if (setup_read) begin
      next_prdata = 32'h0000_0000;
      next_pslverr = 1'b0;
      unique case (paddr)
        gpio_alt_pkg::OFS_B_OUTPUT: next_prdata[7:0] = port_b_output;
        gpio_alt_pkg::OFS_B_DIRECTION: next_prdata[7:0] = port_b_direction;
        gpio_alt_pkg::OFS_B_PIN_LEVEL: next_prdata[7:0] = port_b_pin_level;
        gpio_alt_pkg::OFS_C_OUTPUT: next_prdata[7:0] = port_c_output;
        gpio_alt_pkg::OFS_C_DIRECTION: next_prdata[7:0] = port_c_direction;
        gpio_alt_pkg::OFS_C_PIN_LEVEL: next_prdata[7:0] = port_c_pin_level;
        gpio_alt_pkg::OFS_D_OUTPUT: next_prdata[7:0] = port_d_output;
        gpio_alt_pkg::OFS_D_DIRECTION: next_prdata[7:0] = port_d_direction;
        gpio_alt_pkg::OFS_D_PIN_LEVEL: next_prdata[7:0] = port_d_pin_level;
        gpio_alt_pkg::OFS_ALT_CONTROL: next_prdata[gpio_alt_pkg::CTL_W-1:0] = alt_control;
        gpio_alt_pkg::OFS_PINCHG_MASK: next_prdata[7:0] = pinchg_mask;
        default: next_pslverr = 1'b1;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      prdata <= next_prdata;
      pslverr <= next_pslverr;
    end
  end

  // port d override pairs; only one port carries alternate functions here
  always_comb begin
    pullup_override_en = 8'h00;
    pullup_override_val = 8'h00;
    dir_override_en = 8'h00;
    dir_override_val = 8'h00;
    value_override_en = 8'h00;
    value_override_val = 8'h00;
    din_enable_override_en = pinchg_mask & {8{pinchg_group2_enable}};
    din_enable_override_val = 8'hFF;
    // receive pin: forced input, pull-up still from the data bit
    pullup_override_en[0] = serial_rx_enable;
    pullup_override_val[0] = port_d_output[0] & ~global_pullup_disable;
    dir_override_en[0] = serial_rx_enable;
    dir_override_val[0] = 1'b0;
    // transmit pin: forced output carrying serial data, pull-up off
    pullup_override_en[1] = serial_tx_enable;
    dir_override_en[1] = serial_tx_enable;
    dir_override_val[1] = 1'b1;
    value_override_en[1] = serial_tx_enable;
    value_override_val[1] = serial_tx_data;
    din_enable_override_en[2] = ext_irq_zero_en | (pinchg_mask[2] & pinchg_group1_enable);
    din_enable_override_en[3] = ext_irq_one_en | (pinchg_mask[3] & pinchg_group2_enable);
    value_override_en[3] = alt_control[gpio_alt_pkg::CTL_T2B_EN];
    value_override_val[3] = timer2_cmp_b_out;
    value_override_en[4] = serial_sync_select;
    value_override_val[4] = serial_sync_clock_out;
    value_override_en[5] = alt_control[gpio_alt_pkg::CTL_T0B_EN];
    value_override_val[5] = timer0_cmp_b_out;
    value_override_en[6] = alt_control[gpio_alt_pkg::CTL_T0A_EN];
    value_override_val[6] = timer0_cmp_a_out;
  end

  // per-pin drive: override pair wins, else register setting
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_pin
      always_comb begin
        next_pb_out[gi] = port_b_output[gi];
        next_pb_oe_n[gi] = ~port_b_direction[gi];
        next_pb_pull[gi] = ~port_b_direction[gi] & port_b_output[gi] & ~global_pullup_disable;
        next_pc_out[gi] = port_c_output[gi];
        next_pc_oe_n[gi] = ~port_c_direction[gi];
        next_pc_pull[gi] = ~port_c_direction[gi] & port_c_output[gi] & ~global_pullup_disable;
        next_pd_out[gi] = value_override_en[gi] ? value_override_val[gi]
                                                : port_d_output[gi];
        next_pd_oe_n[gi] = dir_override_en[gi] ? ~dir_override_val[gi]
                                               : ~port_d_direction[gi];
        next_pd_pull[gi] = pullup_override_en[gi] ? pullup_override_val[gi] :
          (~port_d_direction[gi] & port_d_output[gi] & ~global_pullup_disable);
        pd_din_enable[gi] = din_enable_override_en[gi] ? din_enable_override_val[gi]
                                                       : ~din_gate;
      end
    end
  endgenerate

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pb_pin_out <= 8'h00;
      pb_pin_oe_n <= 8'hFF;
      pb_pullup <= 8'h00;
      pc_out_q <= 8'h00;
      pc_oe_n_q <= 8'hFF;
      pc_pull_q <= 8'h00;
      pd_pin_out <= 8'h00;
      pd_pin_oe_n <= 8'hFF;
      pd_pullup <= 8'h00;
    end else begin
      pb_pin_out <= next_pb_out;
      pb_pin_oe_n <= next_pb_oe_n;
      pb_pullup <= next_pb_pull;
      pc_out_q <= next_pc_out;
      pc_oe_n_q <= next_pc_oe_n;
      pc_pull_q <= next_pc_pull;
      pd_pin_out <= next_pd_out;
      pd_pin_oe_n <= next_pd_oe_n;
      pd_pullup <= next_pd_pull;
    end
  end

  assign pc_pin_out = pc_out_q[PORT_C_W-1:0];
  assign pc_pin_oe_n = pc_oe_n_q[PORT_C_W-1:0];
  assign pc_pullup = pc_pull_q[PORT_C_W-1:0];

  // input path: two-stage synchroniser, then gated level register
  always_comb begin
    next_port_b_pin_level = pb_sync2 & {8{~din_gate}};
    next_port_c_pin_level = pc_sync2 & {8{~din_gate}} & gpio_alt_pkg::PORT_C_MASK;
    next_port_d_pin_level = pd_sync2 & pd_din_enable;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pb_sync1 <= 8'h00;
      pb_sync2 <= 8'h00;
      pc_sync1 <= 8'h00;
      pc_sync2 <= 8'h00;
      pd_sync1 <= 8'h00;
      pd_sync2 <= 8'h00;
      port_b_pin_level <= 8'h00;
      port_c_pin_level <= 8'h00;
      port_d_pin_level <= 8'h00;
    end else begin
      pb_sync1 <= pb_pin_in;
      pb_sync2 <= pb_sync1;
      pc_sync1 <= pc_pin_in_w;
      pc_sync2 <= pc_sync1;
      pd_sync1 <= pd_pin_in;
      pd_sync2 <= pd_sync1;
      port_b_pin_level <= next_port_b_pin_level;
      port_c_pin_level <= next_port_c_pin_level;
      port_d_pin_level <= next_port_d_pin_level;
    end
  end

  // peripherals see the same gated level that software reads
  assign serial_rx_data = port_d_pin_level[0];
  assign ext_irq_zero = port_d_pin_level[2];
  assign ext_irq_one = port_d_pin_level[3];
  assign serial_sync_clock_in = port_d_pin_level[4];
  assign timer0_count_in = port_d_pin_level[4];
  assign timer1_count_in = port_d_pin_level[5];
  assign pinchg_src = port_d_pin_level;

  // checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_tx_drive;
    serial_tx_enable |=> !pd_pin_oe_n[1] && pd_pin_out[1] == $past(serial_tx_data);
  endproperty
  a_tx_drive: assert property (p_tx_drive) else $error("tx pin not driven");

  property p_rx_input;
    serial_rx_enable && port_d_direction[0] |=> pd_pin_oe_n[0];
  endproperty
  a_rx_input: assert property (p_rx_input) else $error("rx pin driven");

  property p_rx_pull;
    serial_rx_enable |=> pd_pullup[0] == ($past(port_d_output[0]) && !$past(global_pullup_disable));
  endproperty
  a_rx_pull: assert property (p_rx_pull) else $error("rx pull-up wrong");

  property p_irq1_din;
    ext_irq_one_en && pd_sync2[3] |=> port_d_pin_level[3];
  endproperty
  a_irq1_din: assert property (p_irq1_din) else $error("pin 3 input gated");

  property p_irq0_din;
    (ext_irq_zero_en || (pinchg_mask[2] && pinchg_group1_enable)) && pd_sync2[2]
      |=> ext_irq_zero && pinchg_src[2];
  endproperty
  a_irq0_din: assert property (p_irq0_din) else $error("pin 2 input gated");

  property p_pin4_fanout;
    pinchg_mask[4] && pinchg_group2_enable && pd_sync2[4]
      |=> timer0_count_in && serial_sync_clock_in && pinchg_src[4];
  endproperty
  a_pin4_fanout: assert property (p_pin4_fanout) else $error("pin 4 fanout split");

  property p_b_write;
    wr_access && paddr == gpio_alt_pkg::OFS_B_OUTPUT |=> port_b_output == $past(pwdata[7:0]);
  endproperty
  a_b_write: assert property (p_b_write) else $error("port b write lost");

  property p_b_drive;
    1'b1 |=> pb_pin_oe_n == ~$past(port_b_direction) && pb_pin_out == $past(port_b_output);
  endproperty
  a_b_drive: assert property (p_b_drive) else $error("port b drive wrong");

  property p_c_bit7;
    !port_c_output[7] && !port_c_direction[7] && !port_c_pin_level[7];
  endproperty
  a_c_bit7: assert property (p_c_bit7) else $error("port c bit 7 set");

  property p_pin_sample;
    !din_gate |=> port_b_pin_level == $past(pb_sync2);
  endproperty
  a_pin_sample: assert property (p_pin_sample) else $error("port b level stale");

  c_tx_on: cover property (serial_tx_enable ##1 !pd_pin_oe_n[1]);
  c_rx_pull: cover property (serial_rx_enable && port_d_output[0] ##1 pd_pullup[0]);
  c_read_d: cover property (pready && !pwrite && paddr == gpio_alt_pkg::OFS_D_PIN_LEVEL);
  c_unmapped: cover property (pready && pslverr);

endmodule : gpio_ports_with_alt_override

/* board_pins.sv */
// board circuitry on one port: external drivers, pull-ups and floating lines
// assumes the device marks a driven pin by an active-low output enable
`timescale 1ns/1ps
module board_pins #(
  parameter int W = 8
) (
  // clock for the floating-line pattern
  input wire logic pclk,
  // device side
  input wire logic [W-1:0] pin_out,
  input wire logic [W-1:0] pin_oe_n,
  input wire logic [W-1:0] pull_on,
  // external drivers
  input wire logic [W-1:0] ext_en,
  input wire logic [W-1:0] ext_val,
  output logic [W-1:0] pin_in
);
  // an undriven line without pull-up must not settle to a lucky constant
  logic float_q = 1'b0;

  always @(posedge pclk) begin
    float_q <= ~float_q;
  end

  always_comb begin
    for (int i = 0; i < W; i++) begin
      if (!pin_oe_n[i] && ext_en[i]) begin
        pin_in[i] = 1'bx;
      end else if (!pin_oe_n[i]) begin
        pin_in[i] = pin_out[i];
      end else if (ext_en[i]) begin
        pin_in[i] = ext_val[i];
      end else if (pull_on[i]) begin
        pin_in[i] = 1'b1;
      end else begin
        pin_in[i] = float_q;
      end
    end
  end
endmodule : board_pins

/* tb_gpio_ports_with_alt_override.sv */
// self-checking bench for the three-port gpio block with port d overrides
// assumes a zero-wait apb slave and the board model on every port
`timescale 1ns/1ps
module tb_gpio_ports_with_alt_override;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [7:0] pb_out, pb_oe_n, pb_pu, pb_in, pd_out, pd_oe_n, pd_pu, pd_in, src;
  logic [6:0] pc_out, pc_oe_n, pc_pu, pc_in, ec_en, ec_val;
  logic [7:0] eb_en, eb_val, ed_en, ed_val;
  logic tx_d, sck_o, t0a, t0b, t2b, rx_d, sck_i, irq0, irq1, t0_in, t1_in;
  int n_errors = 0;
  int checked = 0;

  gpio_ports_with_alt_override gpio_ports_with_alt_override_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pb_pin_in(pb_in), .pb_pin_out(pb_out), .pb_pin_oe_n(pb_oe_n), .pb_pullup(pb_pu),
    .pc_pin_in(pc_in), .pc_pin_out(pc_out), .pc_pin_oe_n(pc_oe_n), .pc_pullup(pc_pu),
    .pd_pin_in(pd_in), .pd_pin_out(pd_out), .pd_pin_oe_n(pd_oe_n), .pd_pullup(pd_pu),
    .serial_tx_data(tx_d), .serial_sync_clock_out(sck_o), .timer0_cmp_a_out(t0a),
    .timer0_cmp_b_out(t0b), .timer2_cmp_b_out(t2b), .serial_rx_data(rx_d),
    .serial_sync_clock_in(sck_i), .ext_irq_zero(irq0), .ext_irq_one(irq1),
    .timer0_count_in(t0_in), .timer1_count_in(t1_in), .pinchg_src(src));
  board_pins #(.W(8)) board_pins_inst_b (.pclk(pclk), .pin_out(pb_out), .pin_oe_n(pb_oe_n),
    .pull_on(pb_pu), .ext_en(eb_en), .ext_val(eb_val), .pin_in(pb_in));
  board_pins #(.W(7)) board_pins_inst_c (.pclk(pclk), .pin_out(pc_out), .pin_oe_n(pc_oe_n),
    .pull_on(pc_pu), .ext_en(ec_en), .ext_val(ec_val), .pin_in(pc_in));
  board_pins #(.W(8)) board_pins_inst_d (.pclk(pclk), .pin_out(pd_out), .pin_oe_n(pd_oe_n),
    .pull_on(pd_pu), .ext_en(ed_en), .ext_val(ed_val), .pin_in(pd_in));

  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end

  task chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task apb(input logic [7:0] a, input logic w, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'h1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'h1 && n < 16);
    if (pready !== 1'h1) n_errors++;
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask : apb

  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(a, 1'h1, d);
  endtask : wr

  task rdc(input logic [7:0] a, input logic [31:0] exp);
    apb(a, 1'h0, 32'h0);
    chk(rd, exp);
  endtask : rdc

  // pins take three edges in, outputs one edge out
  task settle;
    repeat (4) @(posedge pclk);
  endtask : settle

  task t_regs;
    logic [7:0] a [6];
    logic [31:0] m [6];
    a = '{gpio_alt_pkg::OFS_B_OUTPUT, gpio_alt_pkg::OFS_B_DIRECTION, gpio_alt_pkg::OFS_C_OUTPUT,
          gpio_alt_pkg::OFS_C_DIRECTION, gpio_alt_pkg::OFS_D_OUTPUT, gpio_alt_pkg::OFS_D_DIRECTION};
    m = '{32'hFF, 32'hFF, 32'h7F, 32'h7F, 32'hFF, 32'hFF};
    chk(32'({pb_oe_n, pd_oe_n}), 32'hFFFF);
    for (int i = 0; i < 6; i++) begin
      rdc(a[i], 32'h0);
      wr(a[i], 32'hFFFF_FFFF);
      rdc(a[i], m[i]);
      wr(a[i], 32'h0);
    end
    apb(8'h2C, 1'h1, 32'hFF);
    chk(32'(err), 32'h1);
    apb(8'h2C, 1'h0, 32'h0);
    chk(rd | 32'(err), 32'h1);
  endtask : t_regs

  task t_pins;
    eb_en <= 8'h0F;
    eb_val <= 8'h05;
    ec_en <= 7'h7F;
    ec_val <= 7'h2A;
    ed_en <= 8'hFF;
    ed_val <= 8'hA5;
    wr(gpio_alt_pkg::OFS_B_OUTPUT, 32'h3C);
    wr(gpio_alt_pkg::OFS_B_DIRECTION, 32'hF0);
    wr(gpio_alt_pkg::OFS_B_PIN_LEVEL, 32'hFF);
    settle;
    chk(32'({pb_pu, ~pb_oe_n, pb_out & ~pb_oe_n}), 32'h0C_F030);
    rdc(gpio_alt_pkg::OFS_B_PIN_LEVEL, 32'h35);
    rdc(gpio_alt_pkg::OFS_C_PIN_LEVEL, 32'h2A);
    wr(gpio_alt_pkg::OFS_C_OUTPUT, 32'h55);
    settle;
    chk(32'({pc_pu, pc_oe_n, pc_out}), 32'({7'h55, 7'h7F, 7'h55}));
    wr(gpio_alt_pkg::OFS_C_OUTPUT, 32'h0);
    rdc(gpio_alt_pkg::OFS_D_PIN_LEVEL, 32'hA5);
    chk(32'(src), 32'hA5);
    chk(32'({irq0, irq1, rx_d, sck_i, t0_in, t1_in}), 32'h29);
    wr(gpio_alt_pkg::OFS_ALT_CONTROL, 32'h001);
    settle;
    chk(32'(pb_pu), 32'h0);
    wr(gpio_alt_pkg::OFS_ALT_CONTROL, 32'h000);
    ed_en <= 8'h00;
  endtask : t_pins

  task t_serial;
    wr(gpio_alt_pkg::OFS_D_DIRECTION, 32'h01);
    wr(gpio_alt_pkg::OFS_D_OUTPUT, 32'h01);
    tx_d <= 1'h1;
    wr(gpio_alt_pkg::OFS_ALT_CONTROL, 32'h006);
    settle;
    chk(32'({pd_oe_n[1:0], pd_out[1], pd_pu[1:0], rx_d}), 32'h1B);
    ed_en <= 8'h01;
    ed_val <= 8'h00;
    tx_d <= 1'h0;
    settle;
    chk(32'({pd_out[1], rx_d}), 32'h0);
    wr(gpio_alt_pkg::OFS_ALT_CONTROL, 32'h007);
    settle;
    chk(32'(pd_pu[0]), 32'h0);
    ed_en <= 8'h00;
    wr(gpio_alt_pkg::OFS_ALT_CONTROL, 32'h000);
    settle;
    chk(32'(pd_oe_n[1:0]), 32'h2);
  endtask : t_serial

  task t_ovr;
    wr(gpio_alt_pkg::OFS_D_DIRECTION, 32'hFF);
    wr(gpio_alt_pkg::OFS_D_OUTPUT, 32'h00);
    {t0a, t0b, t2b, sck_o} <= 4'hA;
    wr(gpio_alt_pkg::OFS_ALT_CONTROL, 32'h708);
    settle;
    chk(32'(pd_out), 32'h48);
    {t0a, t0b, t2b, sck_o} <= 4'h5;
    settle;
    chk(32'(pd_out), 32'h30);
    wr(gpio_alt_pkg::OFS_ALT_CONTROL, 32'h000);
    settle;
    chk(32'(pd_out), 32'h00);
  endtask : t_ovr

  task t_gate;
    logic [11:0] ct [7];
    logic [7:0] mk [7];
    logic [7:0] ex [7];
    ct = '{12'h800, 12'h810, 12'h820, 12'h840, 12'h880, 12'h880, 12'h840};
    mk = '{8'h00, 8'h00, 8'h00, 8'h04, 8'h04, 8'hFB, 8'hFB};
    ex = '{8'h00, 8'h04, 8'h08, 8'h04, 8'h00, 8'hFB, 8'h00};
    wr(gpio_alt_pkg::OFS_D_DIRECTION, 32'h00);
    settle;
    ed_en <= 8'hFF;
    ed_val <= 8'hFF;
    for (int i = 0; i < 7; i++) begin
      wr(gpio_alt_pkg::OFS_PINCHG_MASK, 32'(mk[i]));
      wr(gpio_alt_pkg::OFS_ALT_CONTROL, 32'(ct[i]));
      settle;
      rdc(gpio_alt_pkg::OFS_D_PIN_LEVEL, 32'(ex[i]));
      chk(32'({irq1, irq0, src}), 32'({ex[i][3], ex[i][2], ex[i]}));
      chk(32'({sck_i, t0_in}), 32'({2{ex[i][4]}}));
    end
  endtask : t_gate

  task results;
    $display("errors %0d, comparisons %0d", n_errors, checked);
    if (n_errors == 0 && checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : results

  initial begin
    presetn = 1'h0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {tx_d, sck_o, t0a, t0b, t2b} = '0;
    {eb_en, eb_val, ec_en, ec_val, ed_en, ed_val} = '0;
    repeat (20) @(posedge pclk);
    presetn <= 1'h1;
    t_regs;
    t_pins;
    t_serial;
    t_ovr;
    t_gate;
    results;
  end

  initial begin
    repeat (5000) @(posedge pclk);
    n_errors++;
    results;
  end
endmodule : tb_gpio_ports_with_alt_override
